// ### verilog/fpx_pkg.sv
package fpx_pkg;

	// Control/status register layout
	localparam int          CSR_W     = 32;
	localparam int          RM_LSB    = 0;
	localparam int          RM_W      = 2;
	localparam int          FLAG_LSB  = 2;
	localparam int          EN_LSB    = 7;
	localparam int          CAUSE_LSB = 12;
	localparam int          FN_BIT    = 21;
	localparam logic [31:0] CSR_RST   = 32'h0000_0000;
	localparam logic [31:0] CSR_WMASK = 32'h0023_FFFF;

	// One bit per IEEE condition; cause field adds the unimplemented bit on top
	localparam int COND_W  = 5;
	localparam int CAUSE_W = 6;
	localparam int IDX_I   = 0;
	localparam int IDX_U   = 1;
	localparam int IDX_O   = 2;
	localparam int IDX_Z   = 3;
	localparam int IDX_V   = 4;
	localparam int IDX_E   = 5;
	typedef logic [COND_W-1:0] fpx_cond_t;

	localparam logic [RM_W-1:0] round_nearest_mode = 2'h0;
	localparam logic [RM_W-1:0] round_zero_mode    = 2'h1;
	localparam logic [RM_W-1:0] round_up_mode      = 2'h2;
	localparam logic [RM_W-1:0] round_down_mode    = 2'h3;

	// Single precision encodings
	localparam int          DATA_W                = 32;
	localparam int          SIGN_BIT              = 31;
	localparam logic [31:0] FPX_QNAN              = 32'h7FC0_0000;
	localparam logic [31:0] FPX_INF_MAG           = 32'h7F80_0000;
	localparam logic [31:0] FPX_MAX_MAG           = 32'h7F7F_FFFF;
	localparam logic [31:0] smallest_normal_value = 32'h0080_0000;
	localparam logic [31:0] FPX_ZERO              = 32'h0000_0000;

	typedef enum logic [3:0] {
		FPX_OP_ADD,
		FPX_OP_SUB,
		FPX_OP_MUL,
		FPX_OP_DIV,
		FPX_OP_SQRT,
		FPX_OP_CVT_FIX,
		FPX_OP_CMP,
		FPX_OP_MOVE,
		FPX_OP_OTHER
	} fpx_op_e;

	typedef enum logic [2:0] {
		FPX_CLS_ZERO,
		FPX_CLS_FINITE,
		FPX_CLS_INF,
		FPX_CLS_QNAN,
		FPX_CLS_SNAN
	} fpx_cls_e;

endpackage : fpx_pkg

// ### verilog/fpx_cond_detect.sv
module fpx_cond_detect
	import fpx_pkg::*;
(
	input  wire fpx_pkg::fpx_op_e   op,          // Operation class
	input  wire fpx_pkg::fpx_cls_e  a_cls,       // Operand A class
	input  wire fpx_pkg::fpx_cls_e  b_cls,       // Operand B class
	input  wire logic               a_sign,      // Operand A sign
	input  wire logic               b_sign,      // Operand B sign
	input  wire logic               res_tiny,    // Rounded nonzero result below smallest normal
	input  wire logic               res_inexact, // Rounded result differs from exact
	input  wire logic               res_ovf,     // Rounded magnitude above largest finite
	input  wire logic               cvt_ovf,     // Fixed point conversion out of range
	input  wire logic               cmp_sig_qnan,// Compare kind that signals on quiet NaN
	input  wire logic               en_under,    // Underflow trap enabled
	input  wire logic               en_over,     // Overflow trap enabled
	output fpx_pkg::fpx_cond_t      cond         // Raised IEEE conditions
);
	logic a_nan;
	logic b_nan;
	logic any_snan;
	logic eff_sub;
	logic inv;
	logic dz;
	logic ovf;
	logic unf;
	logic inx;

	always_comb begin
		a_nan    = (a_cls == FPX_CLS_QNAN) || (a_cls == FPX_CLS_SNAN);
		b_nan    = (b_cls == FPX_CLS_QNAN) || (b_cls == FPX_CLS_SNAN);
		any_snan = (a_cls == FPX_CLS_SNAN) || (b_cls == FPX_CLS_SNAN);
		eff_sub  = (op == FPX_OP_SUB) ? (a_sign == b_sign) : (a_sign != b_sign);
		inv = 1'b0;
		if (any_snan && (op != FPX_OP_MOVE))
			inv = 1'b1;
		unique case (op)
			FPX_OP_ADD, FPX_OP_SUB: begin
				if ((a_cls == FPX_CLS_INF) && (b_cls == FPX_CLS_INF) && eff_sub)
					inv = 1'b1;
			end
			FPX_OP_MUL: begin
				if (((a_cls == FPX_CLS_ZERO) && (b_cls == FPX_CLS_INF)) ||
				    ((a_cls == FPX_CLS_INF) && (b_cls == FPX_CLS_ZERO)))
					inv = 1'b1;
			end
			FPX_OP_DIV: begin
				if (((a_cls == FPX_CLS_ZERO) && (b_cls == FPX_CLS_ZERO)) ||
				    ((a_cls == FPX_CLS_INF) && (b_cls == FPX_CLS_INF)))
					inv = 1'b1;
			end
			FPX_OP_SQRT: begin
				// Negative zero is a legal operand
				if (a_sign && ((a_cls == FPX_CLS_FINITE) || (a_cls == FPX_CLS_INF)))
					inv = 1'b1;
			end
			FPX_OP_CVT_FIX: begin
				if (cvt_ovf || (a_cls == FPX_CLS_INF) || a_nan)
					inv = 1'b1;
			end
			FPX_OP_CMP: begin
				if (cmp_sig_qnan && (a_nan || b_nan))
					inv = 1'b1;
			end
			FPX_OP_MOVE, FPX_OP_OTHER: begin
			end
		endcase
		// Only a finite nonzero dividend over zero; inf over zero is silent
		dz = (op == FPX_OP_DIV) && (b_cls == FPX_CLS_ZERO) && (a_cls == FPX_CLS_FINITE) && !inv;
		// At most one condition, except inexact beside overflow or underflow
		ovf = res_ovf && !inv && !dz;
		unf = res_tiny && !inv && !dz && (en_under || res_inexact);
		inx = !inv && !dz && (res_inexact || (ovf && !en_over));
		cond = '0;
		cond[IDX_V] = inv;
		cond[IDX_Z] = dz;
		cond[IDX_O] = ovf;
		cond[IDX_U] = unf;
		cond[IDX_I] = inx;
	end

endmodule : fpx_cond_detect

// ### verilog/fpx_default_result.sv
module fpx_default_result
	import fpx_pkg::*;
(
	input  wire fpx_pkg::fpx_cond_t       cond,        // Raised IEEE conditions
	input  wire logic [fpx_pkg::RM_W-1:0] rmode,       // Rounding mode
	input  wire logic                     flush_nearest_ctl, // Flush control bit
	input  wire logic                     div_sign,    // Sign of quotient
	input  wire logic                     exact_sign,  // Sign of exact result
	input  wire logic [fpx_pkg::DATA_W-1:0] rounded,   // Datapath rounded result
	output logic      [fpx_pkg::DATA_W-1:0] result     // Value to store
);
	logic [DATA_W-1:0] sgn;

	always_comb begin
		sgn    = '0;
		sgn[SIGN_BIT] = exact_sign;
		result = rounded;
		if (cond[IDX_V]) begin
			result = FPX_QNAN;
		end else if (cond[IDX_Z]) begin
			result = FPX_INF_MAG;
			result[SIGN_BIT] = div_sign;
		end else if (cond[IDX_O]) begin
			unique case (rmode)
				round_nearest_mode: result = sgn | FPX_INF_MAG;
				round_zero_mode:    result = sgn | FPX_MAX_MAG;
				round_up_mode:      result = sgn | (exact_sign ? FPX_MAX_MAG : FPX_INF_MAG);
				round_down_mode:    result = sgn | (exact_sign ? FPX_INF_MAG : FPX_MAX_MAG);
			endcase
		end else if (cond[IDX_U] && !flush_nearest_ctl) begin
			unique case (rmode)
				round_nearest_mode: result = sgn | FPX_ZERO;
				round_zero_mode:    result = sgn | FPX_ZERO;
				round_up_mode:      result = exact_sign ? FPX_ZERO : smallest_normal_value;
				round_down_mode:    result = sgn | (exact_sign ? smallest_normal_value : FPX_ZERO);
			endcase
		end
	end

endmodule : fpx_default_result

// ### verilog/fpx_exc_unit.sv
// Operation
// - Trap stops trapping and later instructions
// - Each operation rewrites every cause bit
// - Trap when cause and enable both set
// - Unimplemented cause always traps, no enable
// - Untrapped conditions store IEEE default result
// - Completing instruction ORs raised conditions into flags
// - Only software writes clear flag bits
// - Invalid gives quiet NaN, divzero signed infinity
// - Underflow default depends on rounding mode
// - Inexact gives rounded or overflowed/underflowed value
// - Overflow default depends on mode and sign
// - Signaling NaN operand invalid except moves
// - Zero-infinity products, 0/0, inf/inf, negative sqrt
// - Unrepresentable conversion, some NaN compares invalid
// - Divzero only for finite nonzero dividend
// - Tininess detected after rounding
// - Loss of accuracy means inexact result
// - Untrapped underflow needs tininess and inexact
// - Trapped underflow needs tininess only
// - Overflow when rounded magnitude exceeds largest finite
// - One bit per condition, cause has extra
// - One condition at most, inexact may accompany
module fpx_exc_unit
	import fpx_pkg::*;
(
	input  wire logic                      clk,          // Core clock
	input  wire logic                      sys_rst,      // Synchronous reset, active high
	input  wire logic                      op_valid,     // Operation completes its result stage
	input  wire fpx_pkg::fpx_op_e          op,           // Operation class
	input  wire fpx_pkg::fpx_cls_e         a_cls,        // Operand A class
	input  wire fpx_pkg::fpx_cls_e         b_cls,        // Operand B class
	input  wire logic                      a_sign,       // Operand A sign
	input  wire logic                      b_sign,       // Operand B sign
	input  wire logic                      exact_sign,   // Sign of exact result
	input  wire logic [fpx_pkg::DATA_W-1:0] rounded,     // Rounded datapath result
	input  wire logic                      res_tiny,     // Tiny after rounding, unbounded exponent
	input  wire logic                      res_inexact,  // Rounded result not exact
	input  wire logic                      res_ovf,      // Rounded magnitude above largest finite
	input  wire logic                      cvt_ovf,      // Fixed conversion overflow
	input  wire logic                      cmp_sig_qnan, // Compare that signals on quiet NaN
	input  wire logic                      unimpl,       // Operation needs software emulation
	input  wire logic                      csr_wr,       // Software write of control/status
	input  wire logic [fpx_pkg::CSR_W-1:0] csr_wdata,    // Write data
	output logic      [fpx_pkg::CSR_W-1:0] fp_control_status_reg, // Control/status register
	output logic                           trap_req,     // Precise trap pulse to pipeline
	output logic                           res_valid,    // Operation retired by this unit
	output logic                           res_wr,       // Destination write enable
	output logic      [fpx_pkg::DATA_W-1:0] res_data     // Destination write data
);
	fpx_cond_t               cond;
	fpx_cond_t               enables;
	logic [CAUSE_W-1:0]      op_cause;
	logic [CAUSE_W-1:0]      wr_cause;
	fpx_cond_t               wr_en;
	logic                    op_trap;
	logic [DATA_W-1:0]       dflt;
	logic [CSR_W-1:0]        next_csr;
	logic                    next_trap_req;
	logic                    next_res_valid;
	logic                    next_res_wr;
	logic [DATA_W-1:0]       next_res_data;

	assign enables = fp_control_status_reg[EN_LSB +: COND_W];

	fpx_cond_detect u_detect (
		.op           (op),
		.a_cls        (a_cls),
		.b_cls        (b_cls),
		.a_sign       (a_sign),
		.b_sign       (b_sign),
		.res_tiny     (res_tiny),
		.res_inexact  (res_inexact),
		.res_ovf      (res_ovf),
		.cvt_ovf      (cvt_ovf),
		.cmp_sig_qnan (cmp_sig_qnan),
		.en_under     (enables[IDX_U]),
		.en_over      (enables[IDX_O]),
		.cond         (cond)
	);

	fpx_default_result u_default (
		.cond              (cond),
		.rmode             (fp_control_status_reg[RM_LSB +: RM_W]),
		.flush_nearest_ctl (fp_control_status_reg[FN_BIT]),
		.div_sign          (a_sign ^ b_sign),
		.exact_sign        (exact_sign),
		.rounded           (rounded),
		.result            (dflt)
	);

	always_comb begin
		op_cause        = {unimpl, cond};
		op_trap         = (|(cond & enables)) || unimpl;
		wr_cause        = csr_wdata[CAUSE_LSB +: CAUSE_W];
		wr_en           = csr_wdata[EN_LSB +: COND_W];
		next_csr        = fp_control_status_reg;
		next_trap_req   = 1'b0;
		next_res_valid  = 1'b0;
		next_res_wr     = 1'b0;
		next_res_data   = res_data;
		if (csr_wr) begin
			// Software write replaces flags and causes and is checked at once
			next_csr      = csr_wdata & CSR_WMASK;
			next_trap_req = (|(wr_cause[COND_W-1:0] & wr_en)) || wr_cause[IDX_E];
		end else if (op_valid) begin
			next_csr[CAUSE_LSB +: CAUSE_W] = op_cause;
			next_res_valid = 1'b1;
			if (op_trap) begin
				// Result and flags held back so the stream can be resumed
				next_trap_req = 1'b1;
			end else begin
				next_csr[FLAG_LSB +: COND_W] = fp_control_status_reg[FLAG_LSB +: COND_W] | cond;
				next_res_wr   = 1'b1;
				next_res_data = dflt;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fp_control_status_reg <= CSR_RST;
			trap_req              <= 1'b0;
			res_valid             <= 1'b0;
			res_wr                <= 1'b0;
			res_data              <= FPX_ZERO;
		end else begin
			fp_control_status_reg <= next_csr;
			trap_req              <= next_trap_req;
			res_valid             <= next_res_valid;
			res_wr                <= next_res_wr;
			res_data              <= next_res_data;
		end
	end

endmodule : fpx_exc_unit

// ### verification/fpx_exc_monitor.sv
module fpx_exc_monitor
	import fpx_pkg::*;
(
	input wire logic                      clk,                   // Core clock
	input wire logic                      sys_rst,               // Reset
	input wire logic                      op_valid,              // Op presented
	input wire logic                      csr_wr,                // Write strobe
	input wire logic [fpx_pkg::CSR_W-1:0] csr_wdata,             // Write data
	input wire logic                      unimpl,                // Unimplemented op
	input wire logic [fpx_pkg::CSR_W-1:0] fp_control_status_reg, // Register
	input wire logic                      trap_req,              // Trap pulse
	input wire logic                      res_valid,             // Retire pulse
	input wire logic                      res_wr                 // Destination write
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_op_retires: assert property (op_valid && !csr_wr |=> res_valid && (res_wr != trap_req))
		else $error("op retire wrong");
	a_trap_no_write: assert property (trap_req |-> !res_wr)
		else $error("trapped op wrote");
	a_trap_op_cause: assert property (res_valid |-> trap_req == ((|(fp_control_status_reg[16:12]
		& fp_control_status_reg[11:7])) || fp_control_status_reg[17]))
		else $error("op trap mismatch");
	a_trap_on_write: assert property (csr_wr |=> trap_req == ((|(fp_control_status_reg[16:12]
		& fp_control_status_reg[11:7])) || fp_control_status_reg[17]))
		else $error("write trap mismatch");
	a_write_beats_op: assert property (csr_wr |=> !res_valid && !res_wr)
		else $error("op taken during write");
	a_unimpl_traps: assert property (op_valid && !csr_wr && unimpl |=> trap_req && fp_control_status_reg[17])
		else $error("unimpl no trap");
	a_write_masked: assert property (csr_wr |=> fp_control_status_reg == ($past(csr_wdata) & CSR_WMASK))
		else $error("write value wrong");
	a_flags_grow: assert property (res_wr |-> fp_control_status_reg[6:2]
		== ($past(fp_control_status_reg[6:2]) | fp_control_status_reg[16:12]))
		else $error("flags wrong");
	a_trap_flags_hold: assert property (res_valid && trap_req |-> $stable(fp_control_status_reg[6:2]))
		else $error("trap changed flags");
	a_one_cond: assert property (res_valid && (|fp_control_status_reg[16:15]) |->
		$onehot(fp_control_status_reg[16:15]) && fp_control_status_reg[14:12] == 3'h0)
		else $error("conditions combined");
endmodule : fpx_exc_monitor

bind fpx_exc_unit fpx_exc_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .csr_wr(csr_wr),
	.csr_wdata(csr_wdata), .unimpl(unimpl), .fp_control_status_reg(fp_control_status_reg),
	.trap_req(trap_req), .res_valid(res_valid), .res_wr(res_wr));

// ### verification/fpx_sw_model.sv
module fpx_sw_model
	import fpx_pkg::*;
(
	input  wire logic                      clk,       // Core clock
	input  wire logic [fpx_pkg::CSR_W-1:0] csr,       // Register read back
	output logic                           csr_wr,    // Write strobe
	output logic      [fpx_pkg::CSR_W-1:0] csr_wdata  // Write data
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		csr_wr    = 1'b0;
		csr_wdata = 32'h0000_0000;
	end

	// Data is scrambled after the taking edge so stale values are never seen
	task automatic write_csr(input logic [CSR_W-1:0] d);
		csr_wr    <= 1'b1;
		csr_wdata <= d;
		@(posedge clk);
		#2;
		csr_wr    <= 1'b0;
		csr_wdata <= ~d;
	endtask : write_csr

	// Clear enabled and unimplemented causes before resuming
	task automatic handle_trap();
		logic [CSR_W-1:0] m;
		m = 32'h0002_0000 | {15'h0000, csr[11:7], 12'h000};
		write_csr(csr & ~m);
	endtask : handle_trap
endmodule : fpx_sw_model

// ### verification/tb.sv
module tb
	import fpx_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk, sys_rst, op_valid, a_sign, b_sign, exact_sign, csr_wr, trap_req, res_valid, res_wr;
	logic        res_tiny, res_inexact, res_ovf, cvt_ovf, cmp_sig_qnan, unimpl;
	fpx_op_e     op;
	fpx_cls_e    a_cls, b_cls;
	logic [31:0] rounded, csr_wdata, fp_control_status_reg, res_data, rnd, ecsr, x, y;
	logic [1:0]  md;
	int          mismatches, comparisons;

	fpx_exc_unit DUT (.clk, .sys_rst, .op_valid, .op, .a_cls, .b_cls, .a_sign, .b_sign, .exact_sign, .rounded,
		.res_tiny, .res_inexact, .res_ovf, .cvt_ovf, .cmp_sig_qnan, .unimpl, .csr_wr, .csr_wdata,
		.fp_control_status_reg, .trap_req, .res_valid, .res_wr, .res_data);
	fpx_sw_model SW (.clk, .csr(fp_control_status_reg), .csr_wr, .csr_wdata);

	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	task automatic chk_val(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_bit(input logic got, exp);
		chk_val({31'h0, got}, {31'h0, exp});
	endtask : chk_bit

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	// fl = {tiny, inexact, ovf, cvt_ovf, cmp_sig_qnan, unimpl}, c = expected cause
	task automatic op_go(input fpx_op_e o, input fpx_cls_e ac, bc, input logic [2:0] sg,
		input logic [5:0] fl, c, input logic [31:0] d);
		logic t;
		t = (|(c[4:0] & ecsr[11:7])) | c[5];
		op <= o;
		a_cls <= ac;
		b_cls <= bc;
		{op_valid, a_sign, b_sign, exact_sign} <= {1'b1, sg};
		{res_tiny, res_inexact, res_ovf, cvt_ovf, cmp_sig_qnan, unimpl} <= fl;
		rounded <= rnd;
		@(posedge clk);
		#2;
		op_valid <= 1'b0;
		ecsr = {ecsr[31:18], c, ecsr[11:7], ecsr[6:2] | (t ? 5'h00 : c[4:0]), ecsr[1:0]};
		chk_val(fp_control_status_reg, ecsr);
		chk_bit(trap_req, t);
		chk_bit(res_wr, !t);
		chk_bit(res_valid, 1'b1);
		if (!t)
			chk_val(res_data, d);
		rnd = rnd + 32'h0101_0101;
		@(posedge clk);
		#2;
	endtask : op_go

	task automatic wr_chk();
		chk_val(fp_control_status_reg, ecsr);
		chk_bit(trap_req, (|(ecsr[16:12] & ecsr[11:7])) | ecsr[17]);
		@(posedge clk);
		#2;
	endtask : wr_chk

	task automatic sw_wr(input logic [31:0] d);
		SW.write_csr(d);
		ecsr = d & CSR_WMASK;
		wr_chk();
	endtask : sw_wr

	task automatic sw_clear();
		ecsr = ecsr & ~(32'h0002_0000 | {15'h0000, ecsr[11:7], 12'h000});
		SW.handle_trap();
		wr_chk();
	endtask : sw_clear

	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		summarize();
	end

	initial begin
		{sys_rst, op_valid, a_sign, b_sign, exact_sign} = 5'h10;
		{res_tiny, res_inexact, res_ovf, cvt_ovf, cmp_sig_qnan, unimpl} = 6'h00;
		op = FPX_OP_ADD;
		a_cls = FPX_CLS_ZERO;
		b_cls = FPX_CLS_ZERO;
		{rounded, ecsr} = 64'h0;
		rnd = 32'h3F80_0001;
		{mismatches, comparisons} = 64'h0;
		repeat (4) @(posedge clk);
		#2;
		sys_rst <= 1'b0;
		chk_val(fp_control_status_reg, 32'h0);
		chk_bit(res_valid, 1'b0);
		@(posedge clk);
		#2;
		op_go(FPX_OP_MUL, FPX_CLS_ZERO, FPX_CLS_INF, 3'h0, 6'h00, 6'h10, FPX_QNAN);
		op_go(FPX_OP_DIV, FPX_CLS_ZERO, FPX_CLS_ZERO, 3'h0, 6'h00, 6'h10, FPX_QNAN);
		op_go(FPX_OP_DIV, FPX_CLS_INF, FPX_CLS_INF, 3'h0, 6'h00, 6'h10, FPX_QNAN);
		op_go(FPX_OP_SQRT, FPX_CLS_FINITE, FPX_CLS_ZERO, 3'h4, 6'h00, 6'h10, FPX_QNAN);
		op_go(FPX_OP_SQRT, FPX_CLS_ZERO, FPX_CLS_ZERO, 3'h4, 6'h00, 6'h00, rnd);
		op_go(FPX_OP_SUB, FPX_CLS_INF, FPX_CLS_INF, 3'h0, 6'h00, 6'h10, FPX_QNAN);
		op_go(FPX_OP_ADD, FPX_CLS_SNAN, FPX_CLS_FINITE, 3'h0, 6'h00, 6'h10, FPX_QNAN);
		op_go(FPX_OP_MOVE, FPX_CLS_SNAN, FPX_CLS_FINITE, 3'h0, 6'h00, 6'h00, rnd);
		op_go(FPX_OP_CVT_FIX, FPX_CLS_FINITE, FPX_CLS_ZERO, 3'h0, 6'h04, 6'h10, FPX_QNAN);
		op_go(FPX_OP_CVT_FIX, FPX_CLS_INF, FPX_CLS_ZERO, 3'h0, 6'h00, 6'h10, FPX_QNAN);
		op_go(FPX_OP_CMP, FPX_CLS_QNAN, FPX_CLS_FINITE, 3'h0, 6'h02, 6'h10, FPX_QNAN);
		op_go(FPX_OP_DIV, FPX_CLS_FINITE, FPX_CLS_ZERO, 3'h4, 6'h00, 6'h08, 32'hFF80_0000);
		op_go(FPX_OP_DIV, FPX_CLS_INF, FPX_CLS_ZERO, 3'h4, 6'h00, 6'h00, rnd);
		op_go(FPX_OP_ADD, FPX_CLS_FINITE, FPX_CLS_FINITE, 3'h0, 6'h10, 6'h01, rnd);
		op_go(FPX_OP_MUL, FPX_CLS_FINITE, FPX_CLS_FINITE, 3'h0, 6'h20, 6'h00, rnd);
		$display("test conditions ended");
		sw_wr(32'h0000_0100);
		op_go(FPX_OP_MUL, FPX_CLS_FINITE, FPX_CLS_FINITE, 3'h0, 6'h20, 6'h02, 32'h0);
		sw_clear();
		sw_wr(32'hFFDC_1CFC);
		sw_clear();
		op_go(FPX_OP_ADD, FPX_CLS_FINITE, FPX_CLS_FINITE, 3'h0, 6'h01, 6'h20, 32'h0);
		sw_clear();
		op_go(FPX_OP_ADD, FPX_CLS_FINITE, FPX_CLS_FINITE, 3'h0, 6'h10, 6'h01, 32'h0);
		sw_clear();
		sw_wr(32'h0000_0000);
		sw_wr(32'h0000_0200);
		op_go(FPX_OP_MUL, FPX_CLS_FINITE, FPX_CLS_FINITE, 3'h0, 6'h08, 6'h04, 32'h0);
		sw_clear();
		sw_wr(32'h0020_0000);
		op_go(FPX_OP_MUL, FPX_CLS_FINITE, FPX_CLS_FINITE, 3'h0, 6'h30, 6'h03, rnd);
		op_go(FPX_OP_OTHER, FPX_CLS_FINITE, FPX_CLS_FINITE, 3'h0, 6'h10, 6'h01, rnd);
		// Operation presented beside a software write must be dropped
		op_valid <= 1'b1;
		SW.write_csr(32'h0000_0003);
		op_valid <= 1'b0;
		ecsr = 32'h0000_0003;
		chk_bit(res_valid, 1'b0);
		chk_bit(res_wr, 1'b0);
		wr_chk();
		$display("test traps ended");
		for (int m = 0; m < 4; m++) begin
			for (int s = 0; s < 2; s++) begin
				md = 2'(m);
				sw_wr(32'(m));
				x = (md == round_nearest_mode || (md >= round_up_mode && md[0] == s[0])) ? FPX_INF_MAG : FPX_MAX_MAG;
				op_go(FPX_OP_MUL, FPX_CLS_FINITE, FPX_CLS_FINITE, 3'(s), 6'h08, 6'h05, {s[0], x[30:0]});
				y = (md >= round_up_mode && md[0] == s[0]) ? {s[0], smallest_normal_value[30:0]} : FPX_ZERO;
				y = (md < round_up_mode) ? {s[0], 31'h0} : y;
				op_go(FPX_OP_MUL, FPX_CLS_FINITE, FPX_CLS_FINITE, 3'(s), 6'h30, 6'h03, y);
			end
		end
		$display("test rounding ended");
		summarize();
	end
endmodule : tb
